// ---- verilog/qltx_quad_lane_tx_port.sv ----
// Purpose: double-edge capture of four transmit lanes and hand-off to the core
// Assumes: channel_sync_select and the encode enable are static straps
// Notes:   one ten-bit word per lane per core cycle, rise capture first
`timescale 1ns/1ps
module qltx_quad_lane_tx_port (
   // core clock and reset
   input  wire logic                                           CORE_CLK,
   input  wire logic                                           RST,
   // straps
   input  wire logic                                           CHIP_RESET_N,
   input  wire logic                                           ENCODE_ENABLE,
   input  wire logic                                           CHANNEL_SYNC_SELECT,
   // lane transmit clocks
   input  wire logic                                           LANE_A_TX_CLOCK,
   input  wire logic                                           LANE_B_TX_CLOCK,
   input  wire logic                                           LANE_C_TX_CLOCK,
   input  wire logic                                           LANE_D_TX_CLOCK,
   // lane transmit data
   input  wire logic [qltx_pkg::DATA_W-1:0]                    LANE_A_TX_BITS,
   input  wire logic                                           LANE_A_NINTH_TX_BIT,
   input  wire logic                                           LANE_A_TENTH_TX_BIT,
   input  wire logic [qltx_pkg::DATA_W-1:0]                    LANE_B_TX_BITS,
   input  wire logic                                           LANE_B_NINTH_TX_BIT,
   input  wire logic                                           LANE_B_TENTH_TX_BIT,
   input  wire logic [qltx_pkg::DATA_W-1:0]                    LANE_C_TX_BITS,
   input  wire logic                                           LANE_C_NINTH_TX_BIT,
   input  wire logic                                           LANE_C_TENTH_TX_BIT,
   input  wire logic [qltx_pkg::DATA_W-1:0]                    LANE_D_TX_BITS,
   input  wire logic                                           LANE_D_NINTH_TX_BIT,
   input  wire logic                                           LANE_D_TENTH_TX_BIT,
   // back-pressure toward the controller, in each lane capture domain
   output logic      [qltx_pkg::NUM_LANES-1:0]                 TX_LANE_READY,
   // words toward the serialiser path
   output qltx_pkg::qltx_word_s [qltx_pkg::NUM_LANES-1:0]      TX_WORD,
   output logic      [qltx_pkg::NUM_LANES-1:0]                 TX_WORD_VALID,
   input  wire logic [qltx_pkg::NUM_LANES-1:0]                 TX_WORD_READY,
   // coder enables
   output logic                                                TX_ENCODE_EN,
   output logic                                                RX_DECODE_EN
);
   localparam int NL = qltx_pkg::NUM_LANES;

   logic                     chip_reset_n_s1_reg;
   logic                     chip_reset_n_s2_reg;
   logic                     code_s1_reg;
   logic                     code_s2_reg;
   logic                     flush;
   logic [NL-1:0]            tx_clk_pin;
   logic [NL-1:0]            lane_clk;
   qltx_pkg::qltx_lane_in_s  lane_pin [NL];

   function automatic qltx_pkg::qltx_word_s to_word(input qltx_pkg::qltx_lane_in_s b,
                                                    input logic enc);
      qltx_pkg::qltx_word_s w;
      w = '0;
      if (enc) begin
         w.k_req  = b.ninth;
         w.symbol = {2'b00, b.data};
      end else begin
         w.k_req  = 1'b0;
         w.symbol = {b.tenth, b.ninth, b.data};
      end
      return w;
   endfunction

   // chip reset and encode enable straps into the core domain
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         chip_reset_n_s1_reg <= 1'b0;
         chip_reset_n_s2_reg <= 1'b0;
         code_s1_reg <= 1'b0;
         code_s2_reg <= 1'b0;
      end else begin
         chip_reset_n_s1_reg <= CHIP_RESET_N;
         chip_reset_n_s2_reg <= chip_reset_n_s1_reg;
         code_s1_reg <= ENCODE_ENABLE;
         code_s2_reg <= code_s1_reg;
      end
   end

   assign flush        = RST || !chip_reset_n_s2_reg;
   assign TX_ENCODE_EN = code_s2_reg;
   assign RX_DECODE_EN = code_s2_reg;

   assign tx_clk_pin = {LANE_D_TX_CLOCK, LANE_C_TX_CLOCK, LANE_B_TX_CLOCK, LANE_A_TX_CLOCK};
   assign lane_pin[0] = '{LANE_A_TENTH_TX_BIT, LANE_A_NINTH_TX_BIT, LANE_A_TX_BITS};
   assign lane_pin[1] = '{LANE_B_TENTH_TX_BIT, LANE_B_NINTH_TX_BIT, LANE_B_TX_BITS};
   assign lane_pin[2] = '{LANE_C_TENTH_TX_BIT, LANE_C_NINTH_TX_BIT, LANE_C_TX_BITS};
   assign lane_pin[3] = '{LANE_D_TENTH_TX_BIT, LANE_D_NINTH_TX_BIT, LANE_D_TX_BITS};

   for (genvar i = 0; i < NL; i++) begin : g_lane
      logic                    lrst_s1_reg;
      logic                    lrst_s2_reg;
      qltx_pkg::qltx_lane_in_s rise_reg;
      qltx_pkg::qltx_lane_in_s rise_next;
      qltx_pkg::qltx_lane_in_s fall_reg;
      qltx_pkg::qltx_lane_in_s fall_next;
      logic                    primed_reg;
      logic                    primed_next;
      qltx_pkg::qltx_pair_s    pair_w;
      qltx_pkg::qltx_pair_s    pair_r;
      logic                    pair_valid;
      logic                    pop;
      qltx_pkg::qltx_half_e    half_reg;
      qltx_pkg::qltx_half_e    half_next;
      qltx_pkg::qltx_word_s    word_reg;
      qltx_pkg::qltx_word_s    word_next;
      logic                    wvalid_reg;
      logic                    wvalid_next;
      logic                    advance;

      // static mux: strap may change only while the chip is held in reset
      if (i == qltx_pkg::LANE_A) begin : g_own
         assign lane_clk[i] = tx_clk_pin[qltx_pkg::LANE_A];
      end else begin : g_sel
         assign lane_clk[i] = CHANNEL_SYNC_SELECT ? tx_clk_pin[qltx_pkg::LANE_A]
                                                  : tx_clk_pin[i];
      end

      // flush into the lane clock domain
      always_ff @(posedge lane_clk[i]) begin
         lrst_s1_reg <= flush;
         lrst_s2_reg <= lrst_s1_reg;
      end

      // all ten lane bits share the selected clock on both edges
      always_comb begin
         rise_next   = lane_pin[i];
         fall_next   = lane_pin[i];
         primed_next = 1'b1;
      end

      always_ff @(posedge lane_clk[i]) begin
         if (lrst_s2_reg) begin
            rise_reg   <= '0;
            primed_reg <= 1'b0;
         end else begin
            rise_reg   <= rise_next;
            primed_reg <= primed_next;
         end
      end

      always_ff @(negedge lane_clk[i]) begin
         if (lrst_s2_reg) begin
            fall_reg <= '0;
         end else begin
            fall_reg <= fall_next;
         end
      end

      // pushed at the rising edge after the falling capture
      assign pair_w = '{rise_reg, fall_reg};

      qltx_async_fifo #(
         .WIDTH (qltx_pkg::PAIR_W),
         .DEPTH (qltx_pkg::FIFO_DEPTH)
      ) u_fifo (
         .wr_clk   (lane_clk[i]),
         .wr_rst   (lrst_s2_reg),
         .wr_valid (primed_reg),
         .wr_ready (TX_LANE_READY[i]),
         .wr_data  (pair_w),
         .rd_clk   (CORE_CLK),
         .rd_rst   (flush),
         .rd_valid (pair_valid),
         .rd_ready (pop),
         .rd_data  (pair_r)
      );

      // unpack one word per core cycle
      always_comb begin
         advance     = (!wvalid_reg || TX_WORD_READY[i]) && pair_valid;
         pop         = advance && (half_reg == qltx_pkg::QLTX_FALL);
         half_next   = half_reg;
         word_next   = word_reg;
         wvalid_next = wvalid_reg && !TX_WORD_READY[i];
         if (advance) begin
            wvalid_next = 1'b1;
            if (half_reg == qltx_pkg::QLTX_RISE) begin
               word_next = to_word(pair_r.rise, code_s2_reg);
               half_next = qltx_pkg::QLTX_FALL;
            end else begin
               word_next = to_word(pair_r.fall, code_s2_reg);
               half_next = qltx_pkg::QLTX_RISE;
            end
         end
      end

      always_ff @(posedge CORE_CLK) begin
         if (flush) begin
            half_reg   <= qltx_pkg::QLTX_RISE;
            word_reg   <= '0;
            wvalid_reg <= 1'b0;
         end else begin
            half_reg   <= half_next;
            word_reg   <= word_next;
            wvalid_reg <= wvalid_next;
         end
      end

      assign TX_WORD[i]       = word_reg;
      assign TX_WORD_VALID[i] = wvalid_reg;
   end
endmodule

// ---- verilog/qltx_pkg.sv ----
// Purpose: shared constants and carriers of the quad-lane transmit input port
// Assumes: four lanes, eight data bits plus two extra bits per lane
// Notes:   capture pairs are rise word first, fall word second
package qltx_pkg;
   localparam int NUM_LANES  = 4;
   localparam int DATA_W     = 8;
   localparam int SYM_W      = 10;
   localparam int FIFO_DEPTH = 32;
   localparam int LANE_A     = 0;

   typedef struct packed {
      logic              tenth;
      logic              ninth;
      logic [DATA_W-1:0] data;
   } qltx_lane_in_s;

   typedef struct packed {
      qltx_lane_in_s rise;
      qltx_lane_in_s fall;
   } qltx_pair_s;

   typedef struct packed {
      logic             k_req;
      logic [SYM_W-1:0] symbol;
   } qltx_word_s;

   typedef enum logic [0:0] {
      QLTX_RISE = 1'b0,
      QLTX_FALL = 1'b1
   } qltx_half_e;

   localparam int PAIR_W = $bits(qltx_pair_s);
endpackage

// ---- verilog/qltx_async_fifo.sv ----
// Purpose: dual-clock FIFO carrying captured lane pairs into the core domain
// Assumes: DEPTH is a power of two, at least four
// Notes:   gray pointers cross in two flops; read data come from a register
`timescale 1ns/1ps
module qltx_async_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 32
) (
   // write side
   input  wire logic             wr_clk,
   input  wire logic             wr_rst,
   input  wire logic             wr_valid,
   output logic                  wr_ready,
   input  wire logic [WIDTH-1:0] wr_data,
   // read side
   input  wire logic             rd_clk,
   input  wire logic             rd_rst,
   output logic                  rd_valid,
   input  wire logic             rd_ready,
   output logic      [WIDTH-1:0] rd_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wbin_reg;
   logic [AW:0]      wbin_next;
   logic [AW:0]      wgray_reg;
   logic [AW:0]      wgray_next;
   logic [AW:0]      rq1_reg;
   logic [AW:0]      rq2_reg;
   logic [AW:0]      rbin_reg;
   logic [AW:0]      rbin_next;
   logic [AW:0]      rgray_reg;
   logic [AW:0]      rgray_next;
   logic [AW:0]      wq1_reg;
   logic [AW:0]      wq2_reg;
   logic             rvalid_reg;
   logic             rvalid_next;
   logic [WIDTH-1:0] rdata_reg;
   logic [WIDTH-1:0] rdata_next;
   logic             push;
   logic             load;

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   // write domain
   always_comb begin
      wr_ready   = wgray_reg != {~rq2_reg[AW:AW-1], rq2_reg[AW-2:0]};
      push       = wr_valid && wr_ready;
      wbin_next  = wbin_reg + {{AW{1'b0}}, push};
      wgray_next = to_gray(wbin_next);
   end

   always_ff @(posedge wr_clk) begin
      if (wr_rst) begin
         wbin_reg  <= '0;
         wgray_reg <= '0;
         rq1_reg   <= '0;
         rq2_reg   <= '0;
      end else begin
         wbin_reg  <= wbin_next;
         wgray_reg <= wgray_next;
         rq1_reg   <= rgray_reg;
         rq2_reg   <= rq1_reg;
      end
   end

   always_ff @(posedge wr_clk) begin
      if (push) begin
         mem[wbin_reg[AW-1:0]] <= wr_data;
      end
   end

   // read domain
   always_comb begin
      load        = (rgray_reg != wq2_reg) && (!rvalid_reg || rd_ready);
      rbin_next   = rbin_reg + {{AW{1'b0}}, load};
      rgray_next  = to_gray(rbin_next);
      rvalid_next = load ? 1'b1 : (rd_ready ? 1'b0 : rvalid_reg);
      rdata_next  = load ? mem[rbin_reg[AW-1:0]] : rdata_reg;
   end

   always_ff @(posedge rd_clk) begin
      if (rd_rst) begin
         rbin_reg   <= '0;
         rgray_reg  <= '0;
         wq1_reg    <= '0;
         wq2_reg    <= '0;
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
      end else begin
         rbin_reg   <= rbin_next;
         rgray_reg  <= rgray_next;
         wq1_reg    <= wgray_reg;
         wq2_reg    <= wq1_reg;
         rvalid_reg <= rvalid_next;
         rdata_reg  <= rdata_next;
      end
   end

   assign rd_valid = rvalid_reg;
   assign rd_data  = rdata_reg;
endmodule

// ---- sim/qltx_port_sva.sv ----
// Purpose: port assertions for the quad-lane transmit input port
// Assumes: straps change only while the word stream is idle
// Notes:   bound to the top module below
`timescale 1ns/1ps
module qltx_port_sva (
   // core side
   input wire logic                                      CORE_CLK,
   input wire logic                                      RST,
   input wire logic                                      CHIP_RESET_N,
   input wire logic                                      ENCODE_ENABLE,
   // word stream
   input wire qltx_pkg::qltx_word_s [qltx_pkg::NUM_LANES-1:0] TX_WORD,
   input wire logic [qltx_pkg::NUM_LANES-1:0]            TX_WORD_VALID,
   input wire logic [qltx_pkg::NUM_LANES-1:0]            TX_WORD_READY,
   // coder enables
   input wire logic                                      TX_ENCODE_EN,
   input wire logic                                      RX_DECODE_EN
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   // set once a rise word was taken, so a fall word is due
   logic [3:0] fall_due_reg;
   logic [3:0] fall_due_next;
   always_comb fall_due_next = (RST || !CHIP_RESET_N) ? 4'h0
                               : fall_due_reg ^ (TX_WORD_VALID & TX_WORD_READY);
   always_ff @(posedge CORE_CLK) fall_due_reg <= fall_due_next;

   property p_rst_idle; disable iff (1'b0) RST |=> TX_WORD_VALID == 4'h0; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("word valid in reset");
   property p_flush; (!CHIP_RESET_N) [*5] |-> TX_WORD_VALID == 4'h0; endproperty
   a_flush: assert property (p_flush) else $error("word valid in chip reset");
   property p_enc_follow;
      (CHIP_RESET_N && $stable(ENCODE_ENABLE)) [*8] |-> TX_ENCODE_EN == ENCODE_ENABLE;
   endproperty
   a_enc_follow: assert property (p_enc_follow) else $error("encoder enable lags");
   property p_coder_pair; RX_DECODE_EN == TX_ENCODE_EN; endproperty
   a_coder_pair: assert property (p_coder_pair) else $error("coder enables differ");
   for (genvar l = 0; l < 4; l++) begin : g_lane
      property p_hold;
         TX_WORD_VALID[l] && !TX_WORD_READY[l] && CHIP_RESET_N
            |=> TX_WORD_VALID[l] && $stable(TX_WORD[l]);
      endproperty
      a_hold: assert property (p_hold) else $error("word dropped while stalled");
      property p_k_off; TX_WORD_VALID[l] && !TX_ENCODE_EN |-> !TX_WORD[l].k_req; endproperty
      a_k_off: assert property (p_k_off) else $error("k request with coder off");
      property p_top_zero;
         TX_WORD_VALID[l] && TX_ENCODE_EN |-> TX_WORD[l].symbol[9:8] == 2'b00;
      endproperty
      a_top_zero: assert property (p_top_zero) else $error("extra bits leak");
      property p_fall_next;
         TX_WORD_VALID[l] && TX_WORD_READY[l] && !fall_due_reg[l] && CHIP_RESET_N
            |=> TX_WORD_VALID[l];
      endproperty
      a_fall_next: assert property (p_fall_next) else $error("fall word late");
   end
   c_enc: cover property (TX_ENCODE_EN && TX_WORD_VALID[1] && TX_WORD_READY[1]);
   c_stall: cover property (TX_WORD_VALID[0] && !TX_WORD_READY[0]);
   c_flush: cover property (!CHIP_RESET_N && TX_WORD_VALID != 4'h0);
endmodule

bind qltx_quad_lane_tx_port qltx_port_sva u_sva (.CORE_CLK(CORE_CLK), .RST(RST),
   .CHIP_RESET_N(CHIP_RESET_N), .ENCODE_ENABLE(ENCODE_ENABLE), .TX_WORD(TX_WORD),
   .TX_WORD_VALID(TX_WORD_VALID), .TX_WORD_READY(TX_WORD_READY),
   .TX_ENCODE_EN(TX_ENCODE_EN), .RX_DECODE_EN(RX_DECODE_EN));

// ---- sim/qltx_mac_model.sv ----
// Purpose: controller model driving the four transmit lanes
// Assumes: 6 ns lane period, bits launched a quarter period off each edge
// Notes:   idle clocks stand still; idle lines invert every half cycle
`timescale 1ns/1ps
module qltx_mac_model (
   // lane clocks, bit 0 is lane A
   output logic [3:0]                    lane_clk,
   // lane bits
   output qltx_pkg::qltx_lane_in_s [3:0] lane_in
);
   initial begin
      lane_clk = 4'h0;
      lane_in = '0;
   end
   // lead cycles cover capture start-up; trail edge pushes the last pair
   task automatic send(input int n, input logic [7:0] base, input logic [3:0] mask);
      for (int k = -4; k < 2 * n + 2; k++) begin
         for (int l = 0; l < 4; l++) begin
            if (k >= 0 && k < 2 * n)
               lane_in[l] = {k[1], k[0], base + 8'(k) + 8'(l * 64)};
            else
               lane_in[l] = ~lane_in[l];
         end
         #1.5;
         lane_clk = k[0] ? 4'h0 : mask;
         #1.5;
      end
   endtask
endmodule

// ---- sim/tb_quad_lane_ddr_tx_input_port.sv ----
// Purpose: self-checking bench for the quad-lane transmit input port
// Assumes: straps change only inside a reset
// Notes:   payload found by its first word, then compared in order
`timescale 1ns/1ps
module tb_quad_lane_ddr_tx_input_port;
   logic                          core_clk, rst, chip_n, enc, sync, refused, tx_enc, rx_dec;
   logic [3:0]                    lclk, lane_rdy, w_valid, w_ready;
   qltx_pkg::qltx_lane_in_s [3:0] lin;
   qltx_pkg::qltx_word_s [3:0]    w;
   qltx_pkg::qltx_word_s          got [4][$];
   int                            err_count, checked, cyc;

   qltx_mac_model mac (.lane_clk(lclk), .lane_in(lin));
   qltx_quad_lane_tx_port uut (.CORE_CLK(core_clk), .RST(rst), .CHIP_RESET_N(chip_n),
      .ENCODE_ENABLE(enc), .CHANNEL_SYNC_SELECT(sync), .LANE_A_TX_CLOCK(lclk[0]),
      .LANE_B_TX_CLOCK(lclk[1]), .LANE_C_TX_CLOCK(lclk[2]), .LANE_D_TX_CLOCK(lclk[3]),
      .LANE_A_TX_BITS(lin[0].data), .LANE_A_NINTH_TX_BIT(lin[0].ninth),
      .LANE_A_TENTH_TX_BIT(lin[0].tenth), .LANE_B_TX_BITS(lin[1].data),
      .LANE_B_NINTH_TX_BIT(lin[1].ninth), .LANE_B_TENTH_TX_BIT(lin[1].tenth),
      .LANE_C_TX_BITS(lin[2].data), .LANE_C_NINTH_TX_BIT(lin[2].ninth),
      .LANE_C_TENTH_TX_BIT(lin[2].tenth), .LANE_D_TX_BITS(lin[3].data),
      .LANE_D_NINTH_TX_BIT(lin[3].ninth), .LANE_D_TENTH_TX_BIT(lin[3].tenth),
      .TX_LANE_READY(lane_rdy), .TX_WORD(w), .TX_WORD_VALID(w_valid),
      .TX_WORD_READY(w_ready), .TX_ENCODE_EN(tx_enc), .RX_DECODE_EN(rx_dec));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cyc++;
      if (lane_rdy !== 4'hf && !rst && chip_n) refused = 1'b1;
      for (int l = 0; l < 4; l++)
         if (w_valid[l] && w_ready[l]) got[l].push_back(w[l]);
      if (cyc == 8000) begin
         err_count++;
         tally_and_finish();
      end
   end

   task automatic check(input string what, input logic [10:0] exp, input logic [10:0] seen);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   function automatic logic [10:0] exp_w(input int k, input logic [7:0] b, input int l,
                                         input logic e);
      logic [7:0] d;
      d = b + 8'(k) + 8'(l * 64);
      return e ? {k[0], 2'b00, d} : {1'b0, k[1], k[0], d};
   endfunction

   // lane clocks run during the flush so both sides clear
   task automatic do_reset(input logic e, input logic s);
      @(negedge core_clk);
      {rst, chip_n, enc, sync} = {1'b1, 1'b0, e, s};
      fork mac.send(2, 8'h00, 4'hf); join_none
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      repeat (11) @(negedge core_clk);
      chip_n = 1'b1;
      repeat (8) @(negedge core_clk);
      for (int l = 0; l < 4; l++) got[l].delete();
      check("tx coder enable", 11'(e), 11'(tx_enc));
      check("rx coder enable", 11'(e), 11'(rx_dec));
   endtask

   task automatic run(input int n, input int m, input logic [7:0] b, input logic e,
                      input logic s, input logic [3:0] mask, input logic stall);
      int idx;
      refused = 1'b0;
      w_ready = stall ? 4'h0 : 4'hf;
      mac.send(n, b, mask);
      check("lane refusal seen", 11'(stall), 11'(refused));
      repeat (200) begin
         @(negedge core_clk);
         if (stall) w_ready = ~w_ready;
      end
      for (int l = 0; l < 4; l++) begin
         idx = -1;
         for (int i = got[l].size() - 1; i >= 0; i--)
            if (got[l][i] === exp_w(0, b, l, e)) idx = i;
         if (s || mask[l]) begin
            check("payload present", 11'h1, 11'(idx >= 0 && idx + m <= got[l].size()));
            for (int k = 0; k < m && idx >= 0 && idx + k < got[l].size(); k++)
               check("lane word", exp_w(k, b, l, e), got[l][idx + k]);
         end
      end
   endtask

   task automatic t_plain();
      do_reset(1'b0, 1'b0);
      run(8, 16, 8'h10, 1'b0, 1'b0, 4'he, 1'b0);
      $display("own lane clocks test done");
   endtask

   task automatic t_encode();
      do_reset(1'b1, 1'b0);
      run(8, 16, 8'h20, 1'b1, 1'b0, 4'hf, 1'b0);
      $display("encode test done");
   endtask

   task automatic t_sync();
      do_reset(1'b0, 1'b1);
      run(8, 16, 8'h30, 1'b0, 1'b1, 4'h1, 1'b0);
      $display("lane A clock test done");
   endtask

   task automatic t_fill();
      do_reset(1'b1, 1'b1);
      run(40, 40, 8'h50, 1'b1, 1'b1, 4'h1, 1'b1);
      $display("fill and drain test done");
   endtask

   // chip reset alone, lane clocks running, must drop the stalled words
   task automatic t_flush();
      w_ready = 4'h0;
      mac.send(6, 8'h70, 4'hf);
      repeat (10) @(negedge core_clk);
      chip_n = 1'b0;
      fork mac.send(2, 8'h00, 4'hf); join_none
      repeat (12) @(negedge core_clk);
      chip_n = 1'b1;
      repeat (8) @(negedge core_clk);
      for (int l = 0; l < 4; l++) got[l].delete();
      w_ready = 4'hf;
      repeat (40) @(negedge core_clk);
      check("words after flush", 11'h0, 11'(got[0].size() + got[3].size()));
      $display("flush test done");
   endtask

   initial begin
      {rst, chip_n, enc, sync, refused} = 5'b10000;
      w_ready = 4'hf;
      err_count = 0;
      checked = 0;
      cyc = 0;
      t_plain();
      t_encode();
      t_sync();
      t_fill();
      t_flush();
      tally_and_finish();
   end
endmodule
